// >>> hw/fwp_pkg.sv
// Shared constants, types and register map of the flash word program block
package fwp_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets on the AHB-Lite slave
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_PTR_LOW = 8'h00;
  localparam logic [7:0] OFS_PTR_HIGH = 8'h04;
  localparam logic [7:0] OFS_PTR_UPPER = 8'h08;
  localparam logic [7:0] OFS_TABLE_LATCH = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_KEY = 8'h14;
  localparam logic [7:0] OFS_TBL_WRITE = 8'h18;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STS = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_MODIFY_BIT = 2;
  localparam int CTRL_FAULT_BIT = 3;
  localparam int CTRL_WORD_BIT = 5;
  localparam int IRQ_EN_BIT = 7;
  localparam int TBLWR_INC_BIT = 0;
  localparam int STS_DONE_BIT = 0;
  localparam int STS_FAULT_BIT = 1;
  localparam int STS_REFUSE_BIT = 2;
  localparam int STS_W = 3;
  localparam int PTR_W = 21;

  // ----------------------------------------------------------------------
  // Reset values, unlock keys and timing
  // ----------------------------------------------------------------------
  localparam logic [PTR_W-1:0] PTR_RST = 21'h000000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [STS_W-1:0] STS_RST = 3'h0;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam int CLK_HZ = 50_000_000;
  localparam int FLASH_CYCLE_US = 1000;
  localparam int FLASH_CYCLE_CYC = FLASH_CYCLE_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} fwp_key_t;
  typedef enum logic [1:0] {BUS_RUN, BUS_CTRL, BUS_PROG} fwp_bus_t;

  typedef struct packed {
    logic [PTR_W-1:0] addr;
    logic [15:0] data;
  } fwp_flash_req_t;

  typedef struct packed {
    logic en;
    logic sel;
    logic [7:0] data;
  } fwp_hold_wr_t;

endpackage

// >>> hw/fwp_hold_mem.sv
// Two-byte holding memory with registered word read-out
`timescale 1ns/1ps
`default_nettype none
module fwp_hold_mem (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire fwp_pkg::fwp_hold_wr_t wr, // Byte write request
  output logic [15:0] rdata // Held word, high byte odd
);
  import fwp_pkg::*;

  logic [7:0] mem_ff [2];
  logic [15:0] rdata_ff;

  // Byte store; never wiped after a program cycle, software overwrites
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mem_ff[0] <= BYTE_RST;
      mem_ff[1] <= BYTE_RST;
    end
    else if (wr.en)
    begin
      mem_ff[wr.sel] <= wr.data;
    end
  end

  // Registered read keeps the word steady toward the array
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_ff <= 16'h0000;
    else
      rdata_ff <= {mem_ff[1], mem_ff[0]};
  end

  assign rdata = rdata_ff;

  hold_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr.en [*2] |=> $stable(rdata))
    else $error("holding word changed without a write");
endmodule
`default_nettype wire

// >>> hw/fwp_cycle_timer.sv
// Internal write duration timer for one flash program cycle
`timescale 1ns/1ps
`default_nettype none
module fwp_cycle_timer #(
  parameter int CYCLES = 50000 // Cycle length in clocks
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic start, // One-cycle start pulse
  input wire logic abort, // Stop the cycle at once
  output logic busy, // Cycle in progress
  output logic done // One-cycle pulse at the end
);
  import fwp_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);

  logic [CW-1:0] cnt_ff;
  logic done_ff;

  // Down counter; abort wins so a reset never reports completion
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (abort)
        cnt_ff <= '0;
      else if (start)
        cnt_ff <= LOAD;
      else if (cnt_ff != '0)
      begin
        cnt_ff <= cnt_ff - 1'b1;
        done_ff <= (cnt_ff == CW'(1));
      end
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = done_ff;

  tmr_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (start && !abort) |=> busy && !done)
    else $error("timer did not start");
endmodule
`default_nettype wire

// >>> hw/fwp_word_prog.sv
// AHB-Lite controller for single-word self-programming of program flash
//
// Functional notes
// - word mode programs one two-byte word
// - modify_enable bit2, single_word_mode bit5 required
// - start only after 55h then AAh keys
// - key register has no storage
// - start stalls core for whole cycle time
// - master clear or watchdog during a program cycle sets fault flag
// - control bits 7, 6, 0 read zero
// - pointer built from three byte registers
// - holding bytes kept after a cycle
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fwp_word_prog #(
  parameter int FLASH_CYC = fwp_pkg::FLASH_CYCLE_CYC // Write time in clocks
) (
  input wire logic hclk, // System clock, 50 MHz
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready, low stalls core
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire logic master_clear_reset, // External clear pin
  input wire logic watchdog_timeout_reset, // Watchdog reset level
  output fwp_pkg::fwp_flash_req_t flash_req, // Word address and data
  output logic flash_prog, // High while array programs
  output logic irq // Interrupt, level
);
  import fwp_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [PTR_W-1:0] ptr_ff;
  logic [7:0] latch_ff;
  logic modify_en_ff, word_ff, start_ff, fault_ff, irq_en_ff;
  fwp_key_t key_ff;
  fwp_bus_t st_ff;
  logic hready_ff, hresp_ff, irq_ff, prog_ff;
  logic [31:0] hrdata_ff;
  logic dp_wr_ff;
  logic [7:0] dp_addr_ff;
  logic [STS_W-1:0] sts_ff, mask_ff;
  fwp_flash_req_t req_ff;
  logic [1:0] clr_sync_ff, wdog_sync_ff;
  logic ctrl_rd_ff, key_rd_ff;
  logic [31:0] prog_cnt_ff;

  logic a_valid, wr_now, ctrl_eval, grant, refuse, abort_lvl;
  logic tmr_busy, tmr_done;
  logic [15:0] hold_word;
  fwp_hold_wr_t hold_wr;
  logic [STS_W-1:0] sts_set;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [7:0] ctrl_view(input logic s, input logic w,
                                           input logic f, input logic m);
    ctrl_view = 8'h00;
    ctrl_view[CTRL_START_BIT] = s;
    ctrl_view[CTRL_MODIFY_BIT] = w;
    ctrl_view[CTRL_FAULT_BIT] = f;
    ctrl_view[CTRL_WORD_BIT] = m;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers for the two reset sources
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clr_sync_ff <= 2'b00;
      wdog_sync_ff <= 2'b00;
    end
    else
    begin
      clr_sync_ff <= {clr_sync_ff[0], master_clear_reset};
      wdog_sync_ff <= {wdog_sync_ff[0], watchdog_timeout_reset};
    end
  end

  assign abort_lvl = clr_sync_ff[1] | wdog_sync_ff[1];

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  assign a_valid = hsel & htrans[1] & hready;
  // Ordinary writes complete in their zero-wait data phase
  assign wr_now = dp_wr_ff & (st_ff == BUS_RUN);
  assign ctrl_eval = (st_ff == BUS_CTRL) & ~abort_lvl;
  // Start is judged against state held before this write
  assign grant = ctrl_eval & hwdata[CTRL_START_BIT] & modify_en_ff & word_ff
               & (key_ff == KEY_OPEN) & ~irq_en_ff;
  assign refuse = ctrl_eval & hwdata[CTRL_START_BIT] & ~grant;

  // Bus phase tracking; a control write takes one wait state, or stalls for the whole cycle when the start is granted
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff <= BUS_RUN;
      hready_ff <= 1'b1;
      dp_wr_ff <= 1'b0;
      dp_addr_ff <= 8'h00;
    end
    else if (abort_lvl)
    begin
      st_ff <= BUS_RUN;
      hready_ff <= 1'b1;
      dp_wr_ff <= 1'b0;
    end
    else
    begin
      unique case (st_ff)
        BUS_RUN:
        begin
          dp_wr_ff <= a_valid & hwrite;
          dp_addr_ff <= haddr[7:0];
          if (a_valid && hwrite && hit(haddr[7:0], OFS_CTRL))
          begin
            st_ff <= BUS_CTRL;
            hready_ff <= 1'b0;
          end
        end
        BUS_CTRL:
        begin
          dp_wr_ff <= 1'b0;
          st_ff <= grant ? BUS_PROG : BUS_RUN;
          hready_ff <= ~grant;
        end
        BUS_PROG:
        begin
          if (tmr_done)
          begin
            st_ff <= BUS_RUN;
            hready_ff <= 1'b1;
          end
        end
      endcase
    end
  end

  // Read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_ff <= 32'h00000000;
      hresp_ff <= 1'b0;
      ctrl_rd_ff <= 1'b0;
      key_rd_ff <= 1'b0;
    end
    else
    begin
      hresp_ff <= 1'b0;
      ctrl_rd_ff <= a_valid & ~hwrite & hit(haddr[7:0], OFS_CTRL);
      key_rd_ff <= a_valid & ~hwrite & hit(haddr[7:0], OFS_KEY);
      if (a_valid && !hwrite)
      begin
        hrdata_ff <= 32'h00000000;
        unique case (haddr[7:0])
          OFS_PTR_LOW: hrdata_ff[7:0] <= ptr_ff[7:0];
          OFS_PTR_HIGH: hrdata_ff[7:0] <= ptr_ff[15:8];
          OFS_PTR_UPPER: hrdata_ff[4:0] <= ptr_ff[20:16];
          OFS_TABLE_LATCH: hrdata_ff[7:0] <= latch_ff;
          OFS_CTRL:
            hrdata_ff[7:0] <= ctrl_view(start_ff, modify_en_ff, fault_ff,
                                        word_ff);
          OFS_IRQ_CTRL: hrdata_ff[IRQ_EN_BIT] <= irq_en_ff;
          OFS_IRQ_STS: hrdata_ff[STS_W-1:0] <= sts_ff;
          OFS_IRQ_MASK: hrdata_ff[STS_W-1:0] <= mask_ff;
          default: hrdata_ff <= 32'h00000000; // Key and holes read zero
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pointer, latch and table writes
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ptr_ff <= PTR_RST;
      latch_ff <= BYTE_RST;
    end
    else if (wr_now)
    begin
      if (hit(dp_addr_ff, OFS_PTR_LOW))
        ptr_ff[7:0] <= hwdata[7:0];
      if (hit(dp_addr_ff, OFS_PTR_HIGH))
        ptr_ff[15:8] <= hwdata[7:0];
      if (hit(dp_addr_ff, OFS_PTR_UPPER))
        ptr_ff[20:16] <= hwdata[4:0];
      if (hit(dp_addr_ff, OFS_TABLE_LATCH))
        latch_ff <= hwdata[7:0];
      // Any table write with bit 0 set steps the pointer
      if (hit(dp_addr_ff, OFS_TBL_WRITE) && hwdata[TBLWR_INC_BIT])
        ptr_ff <= ptr_ff + 1'b1;
    end
  end

  // Pointer bit 0 picks the byte: even takes low, odd takes high
  always_comb
  begin
    hold_wr.en = wr_now & hit(dp_addr_ff, OFS_TBL_WRITE);
    hold_wr.sel = ptr_ff[0];
    hold_wr.data = latch_ff;
  end

  fwp_hold_mem u_hold (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr(hold_wr),
    .rdata(hold_word)
  );

  // ----------------------------------------------------------------------
  // Unlock sequence observer, no stored key value
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      key_ff <= KEY_IDLE;
    else if (abort_lvl || (ctrl_eval && hwdata[CTRL_START_BIT]))
      key_ff <= KEY_IDLE; // Each start attempt spends the unlock
    else if (wr_now && hit(dp_addr_ff, OFS_KEY))
    begin
      if (hwdata[7:0] == KEY_FIRST)
        key_ff <= KEY_HALF;
      else if (hwdata[7:0] == KEY_SECOND && key_ff == KEY_HALF)
        key_ff <= KEY_OPEN;
      else
        key_ff <= KEY_IDLE;
    end
  end

  // ----------------------------------------------------------------------
  // Control bits, fault flag and global interrupt enable
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      modify_en_ff <= 1'b0;
      word_ff <= 1'b0;
      start_ff <= 1'b0;
      fault_ff <= 1'b0;
      irq_en_ff <= 1'b0;
    end
    else if (abort_lvl)
    begin
      modify_en_ff <= 1'b0;
      word_ff <= 1'b0;
      start_ff <= 1'b0;
      irq_en_ff <= 1'b0;
      // A reset in mid cycle leaves a word of unknown content
      if (st_ff == BUS_PROG)
        fault_ff <= 1'b1;
    end
    else
    begin
      if (ctrl_eval)
      begin
        modify_en_ff <= hwdata[CTRL_MODIFY_BIT];
        word_ff <= hwdata[CTRL_WORD_BIT];
        fault_ff <= fault_ff & hwdata[CTRL_FAULT_BIT];
      end
      if (grant)
        start_ff <= 1'b1;
      else if (tmr_done)
        start_ff <= 1'b0;
      if (wr_now && hit(dp_addr_ff, OFS_IRQ_CTRL))
        irq_en_ff <= hwdata[IRQ_EN_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Programming cycle and array request
  // ----------------------------------------------------------------------
  fwp_cycle_timer #(
    .CYCLES(FLASH_CYC)
  ) u_tmr (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(grant),
    .abort(abort_lvl),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // Address is forced even: the word spans the pointer's byte pair
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_ff <= '0;
      prog_ff <= 1'b0;
    end
    else
    begin
      prog_ff <= (grant | tmr_busy) & ~abort_lvl & ~tmr_done;
      if (grant)
      begin
        req_ff.addr <= {ptr_ff[PTR_W-1:1], 1'b0};
        req_ff.data <= hold_word;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------------
  always_comb
  begin
    sts_set = '0;
    sts_set[STS_DONE_BIT] = tmr_done & ~abort_lvl;
    sts_set[STS_FAULT_BIT] = abort_lvl & (st_ff == BUS_PROG);
    sts_set[STS_REFUSE_BIT] = refuse;
  end

  // Write-one-to-clear; a same-cycle event keeps its bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sts_ff <= STS_RST;
      mask_ff <= STS_RST;
      irq_ff <= 1'b0;
    end
    else
    begin
      if (wr_now && hit(dp_addr_ff, OFS_IRQ_STS))
        sts_ff <= (sts_ff & ~hwdata[STS_W-1:0]) | sts_set;
      else
        sts_ff <= sts_ff | sts_set;
      if (wr_now && hit(dp_addr_ff, OFS_IRQ_MASK))
        mask_ff <= hwdata[STS_W-1:0];
      irq_ff <= |(sts_ff & mask_ff);
    end
  end

  // Stall length counter, read only by the checks below
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      prog_cnt_ff <= 32'h00000000;
    else if (st_ff != BUS_PROG)
      prog_cnt_ff <= 32'h00000000;
    else
      prog_cnt_ff <= prog_cnt_ff + 32'h00000001;
  end

  assign hreadyout = hready_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign flash_req = req_ff;
  assign flash_prog = prog_ff;
  assign irq = irq_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  stall_length_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == BUS_PROG && tmr_done) |-> prog_cnt_ff == 32'(FLASH_CYC))
    else $error("core stall length wrong");
  key_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_ff == BUS_PROG) |-> $past(key_ff) == KEY_OPEN)
    else $error("start accepted without unlock pair");
  enable_need_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st_ff == BUS_PROG) |-> $past(modify_en_ff) && $past(word_ff))
    else $error("start accepted without enables");
  fault_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (abort_lvl && st_ff == BUS_PROG) |=> fault_ff && hreadyout)
    else $error("interrupted cycle not flagged");
  start_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_ff == BUS_PROG && tmr_done) |=> !start_ff && hreadyout)
    else $error("start bit not cleared at end");
  word_even_a: assert property (@(posedge hclk) disable iff (!hresetn)
    flash_prog |-> flash_req.addr[0] == 1'b0)
    else $error("odd word address presented");
  ctrl_rsvd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_rd_ff |-> hrdata[7:6] == 2'b00 && hrdata[0] == 1'b0)
    else $error("reserved control bits not zero");
  key_nostore_a: assert property (@(posedge hclk) disable iff (!hresetn)
    key_rd_ff |-> hrdata == 32'h00000000)
    else $error("key register returned data");
  irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (|(sts_ff & mask_ff)) |=> irq)
    else $error("unmasked status without interrupt");
endmodule
`default_nettype wire

// >>> testbench/fwp_flash_model.sv
// Behavioural program flash array on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module fwp_flash_model (
  input wire logic hclk, // System clock
  input wire fwp_pkg::fwp_flash_req_t req, // Word address and data
  input wire logic prog // High while the array programs
);
  import fwp_pkg::*;
  logic [15:0] mem [int];
  int writes = 0;
  int faults = 0;
  logic prog_ff = 1'b0;
  // Capture at the first cycle edge; a word may be written once per erase
  always @(posedge hclk)
  begin
    prog_ff <= prog;
    if (prog && !prog_ff)
    begin
      if (mem.exists(int'(req.addr)))
        faults++;
      mem[int'(req.addr)] = req.data;
      writes++;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the flash word program controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fwp_pkg::*;
  // Short program cycle keeps the run brief
  localparam int FC = 16;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic mcr = 1'b0;
  logic wdr = 1'b0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic flash_prog;
  logic irq;
  logic hresp;
  logic [2:0] mask_m = 3'h0;
  fwp_flash_req_t flash_req;
  logic [31:0] rnd = 32'h175BF738;
  logic [31:0] tmp;
  int failures = 0;
  int comparisons = 0;
  int st;
  logic [7:0] ofs [11] = '{OFS_PTR_LOW, OFS_PTR_HIGH, OFS_PTR_UPPER,
    OFS_TABLE_LATCH, OFS_CTRL, OFS_KEY, OFS_TBL_WRITE, OFS_IRQ_CTRL,
    OFS_IRQ_STS, OFS_IRQ_MASK, 8'h30};

  fwp_word_prog #(.FLASH_CYC(FC)) fwp_word_prog_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata),
    .master_clear_reset(mcr), .watchdog_timeout_reset(wdr),
    .flash_req(flash_req), .flash_prog(flash_prog), .irq(irq));

  fwp_flash_model fwp_flash_model_inst (
    .hclk(hclk), .req(flash_req), .prog(flash_prog));

  // 50 MHz clock
  always #10 hclk = ~hclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // One AHB-Lite single transfer; st counts data phase wait states
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    st = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do
    begin
      @(posedge hclk);
      if (hreadyout !== 1'b1)
        st++;
    end
    while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, tmp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, tmp);
    chk(tmp, exp);
  endtask

  // Full word program; ok says whether the start should be granted,
  // brk pulls master clear (1) or watchdog (2) during the stall
  task automatic prog_word(input logic [20:0] a, input logic [15:0] v,
    input bit ld, input logic [7:0] k1, input logic [7:0] k2,
    input logic irq_on, input bit ok, input int brk);
    wr(OFS_PTR_UPPER, {27'h0, a[20:16]});
    wr(OFS_PTR_HIGH, {24'h0, a[15:8]});
    wr(OFS_PTR_LOW, {24'h0, a[7:0]});
    if (ld)
    begin
      wr(OFS_TABLE_LATCH, {24'h0, v[7:0]});
      wr(OFS_TBL_WRITE, 32'h1);
      wr(OFS_TABLE_LATCH, {24'h0, v[15:8]});
      wr(OFS_TBL_WRITE, 32'h0);
    end
    else
      wr(OFS_PTR_LOW, {24'h0, a[7:0] | 8'h01});
    wr(OFS_CTRL, 32'h24);
    wr(OFS_IRQ_CTRL, {24'h0, irq_on, 7'h0});
    wr(OFS_KEY, {24'h0, k1});
    wr(OFS_KEY, {24'h0, k2});
    fork
      xfer(1'b1, OFS_CTRL, 32'h26, tmp);
      if (brk != 0)
      begin
        repeat (4) @(posedge hclk);
        mcr <= (brk == 1);
        wdr <= (brk == 2);
      end
    join
    if (brk != 0)
    begin
      mcr <= 1'b0;
      wdr <= 1'b0;
      repeat (3) @(posedge hclk);
      rd(OFS_CTRL, 32'h08);
      rd(OFS_IRQ_STS, 32'h2);
      wr(OFS_CTRL, 32'h0);
      rd(OFS_CTRL, 32'h0);
    end
    else
    begin
      chk(st, ok ? 2 + FC : 1);
      rd(OFS_PTR_LOW, {24'h0, a[7:0] | 8'h01});
      if (ok)
        chk({16'h0, fwp_flash_model_inst.mem[int'(a)]}, {16'h0, v});
      rd(OFS_CTRL, 32'h24);
      rd(OFS_IRQ_STS, ok ? 32'h1 : 32'h4);
      chk(irq, |(mask_m & (ok ? 3'h1 : 3'h4)));
    end
    wr(OFS_IRQ_STS, 32'h7);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_IRQ_CTRL, 32'h0);
    @(posedge hclk);
    chk(irq, 1'b0);
  endtask

  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard, well above the expected run length
  initial
  begin
    repeat (20000) @(posedge hclk);
    failures++;
    $display("timeout at %0t", $time);
    results();
  end

  initial
  begin
    logic [15:0] w;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values, write-only key and an unmapped place all read zero
    foreach (ofs[i])
      rd(ofs[i], 32'h0);
    wr(OFS_CTRL, 32'hFF);
    rd(OFS_CTRL, 32'h24);
    wr(OFS_CTRL, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      wr(ofs[i], rnd);
      rd(ofs[i], {24'h0, rnd[7:0] & (i == 2 ? 8'h1F : 8'hFF)});
    end
    $display("test pointer done");
    // Refused start with the status masked still keeps irq low
    prog_word(21'h000100, 16'h0, 1, 8'h00, 8'h00, 1'b0, 0, 0);
    wr(OFS_IRQ_MASK, 32'h7);
    mask_m = 3'h7;
    // Good keys, swapped keys, repeated first key, interrupts left on
    for (int c = 0; c < 4; c++)
    begin
      rnd = lfsr(rnd);
      w = rnd[31:16];
      prog_word({rnd[20:1], 1'b0}, w, 1, c == 1 ? 8'hAA : 8'h55,
        c == 1 ? 8'h55 : (c == 2 ? 8'h55 : 8'hAA), c == 3, c == 0, 0);
    end
    $display("test unlock done");
    // Second program reuses the held word without reloading it
    rnd = lfsr(rnd);
    prog_word({rnd[20:1], 1'b0}, w, 0, 8'h55, 8'hAA, 1'b0, 1, 0);
    chk(fwp_flash_model_inst.faults, 0);
    $display("test holding done");
    for (int b = 1; b < 3; b++)
    begin
      rnd = lfsr(rnd);
      prog_word({rnd[20:1], 1'b0}, w, 1, 8'h55, 8'hAA, 1'b0, 1, b);
    end
    $display("test fault done");
    chk(fwp_flash_model_inst.writes, 4);
    results();
  end
endmodule
`default_nettype wire
